// [pin_mux_map.vh]
`ifndef PIN_MUX_MAP_VH
`define PIN_MUX_MAP_VH

// pin function select codes (per pin)
`define FN_QUAD      3'h0
`define FN_TIMER     3'h1
`define FN_SPI       3'h2
`define FN_GPIO      3'h3
`define FN_NONE      3'h4

// bit positions in the port c pull-up enable word
`define PU_PHASE_B_BIT 1
`define PU_INDEX_BIT   2

// pull-up enable reset value, all lines pulled up
`define PU_RESET 16'hffff

`endif

// [encoder_pin_function_mux.v]
// Contract
// R1 - When the phase-B SPI select bit is set, the phase B pin carries the SPI 1 master-out data line.
// R2 - When the index SPI select bit is set, the index pin carries the SPI 1 master-in data line.
// R3 - On the full variant the phase B pin feeds the decoder phase B input after reset until software changes it.
// R4 - On the full variant the index pin feeds the decoder index input after reset until software changes it.
// R5 - On the reduced variant neither pin has a function after reset, so software must choose one first.
// R6 - Clearing bit 1 of the port C pull-up enable turns off the phase B pin pull-up.
// R7 - Clearing bit 2 of the port C pull-up enable turns off the index pin pull-up.
// R8 - In general-purpose mode each of the two port C lines is an input or an output on its own.
// R9 - The master-out line is driven in SPI master mode and is an input in slave mode.
// R10 - The master-in line is an input in SPI master mode and is driven in slave mode.
// R11 - The master presents each master-out bit half a serial clock before the slave samples it.
// R12 - The slave presents each master-in bit half a serial clock before the master samples it.
// R13 - An unselected SPI slave leaves its master-in output undriven.
// R14 - The SPI 1 slave select selects the slave in slave mode and arbitrates masters in master mode; the code only gates the slave with it.
`timescale 1ns/1ps
`include "pin_mux_map.vh"

module encoder_pin_function_mux #(
	parameter FULL_VARIANT = 1
) (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst_b,
	// configuration
	input  wire        i_phase_b_spi_select,
	input  wire        i_index_pin_spi_select,
	input  wire        i_phase_b_timer_select,
	input  wire        i_index_timer_select,
	input  wire        i_phase_b_gpio_select,
	input  wire        i_index_gpio_select,
	input  wire        i_cfg_write,
	// pull-up control
	input  wire [15:0] i_port_c_pullup_enable,
	input  wire        i_pullup_write,
	// spi 1 core side
	input  wire        i_spi_master_mode,
	input  wire        i_spi1_slave_select_in_b,
	input  wire        i_spi_mosi_out,
	input  wire        i_spi_miso_out,
	output reg         o_spi_mosi_in,
	output reg         o_spi_miso_in,
	// timer b channels
	input  wire        i_timer_b_channel_one_out,
	input  wire        i_timer_b_channel_one_oe,
	input  wire        i_timer_b_channel_two_out,
	input  wire        i_timer_b_channel_two_oe,
	output reg         o_timer_b_channel_one,
	output reg         o_timer_b_channel_two,
	// port c lines
	input  wire        i_port_c_line_one_out,
	input  wire        i_port_c_line_one_dir,
	input  wire        i_port_c_line_two_out,
	input  wire        i_port_c_line_two_dir,
	output reg         o_port_c_line_one,
	output reg         o_port_c_line_two,
	// decoder inputs
	output reg         o_quad_phase_b_in,
	output reg         o_quad_index_in,
	// pins
	input  wire        i_phase_b_pin,
	output reg         o_phase_b_pin,
	output reg         o_phase_b_pin_oe,
	output reg         o_phase_b_pullup,
	input  wire        i_index_pin,
	output reg         o_index_pin,
	output reg         o_index_pin_oe,
	output reg         o_index_pullup,
	// status
	output wire [2:0]  o_phase_b_function,
	output wire [2:0]  o_index_function
);

	reg  [2:0] phase_fn_q;
	reg  [2:0] index_fn_q;
	reg        full_q;
	reg        pu_b_q;
	reg        pu_i_q;
	wire       mosi_drive;
	wire       miso_drive;

	// spi wins over timer over gpio; with nothing set the decoder gets the pin
	function [2:0] pick_fn;
		input spi_sel;
		input tmr_sel;
		input gpio_sel;
		begin
			if (spi_sel)
				pick_fn = `FN_SPI;
			else if (tmr_sel)
				pick_fn = `FN_TIMER;
			else if (gpio_sel)
				pick_fn = `FN_GPIO;
			else
				pick_fn = `FN_QUAD;
		end
	endfunction

	// a spi data line is driven only in the direction that the role gives it
	function spi_drives;
		input is_mosi_line;
		input master;
		input slave_sel_b;
		begin
			if (is_mosi_line)
				spi_drives = master;
			else
				spi_drives = !master && !slave_sel_b;
		end
	endfunction

	// slave select only gates the slave; master arbitration is left to the spi core
	assign mosi_drive = spi_drives(1'b1, i_spi_master_mode,
		i_spi1_slave_select_in_b); // [R9]
	assign miso_drive = spi_drives(1'b0, i_spi_master_mode,
		i_spi1_slave_select_in_b); // [R10] [R13] [R14]

	assign o_phase_b_function = phase_fn_q;
	assign o_index_function   = index_fn_q;

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			// reset holds no function; the variant decides on the first edge
			phase_fn_q <= `FN_NONE;
			index_fn_q <= `FN_NONE;
			pu_b_q     <= 1'b1;
			pu_i_q     <= 1'b1;
		end else begin
			if (!full_q) begin
				if (FULL_VARIANT != 0) begin
					phase_fn_q <= `FN_QUAD; // [R3]
					index_fn_q <= `FN_QUAD; // [R4]
				end
			end
			// reduced variant stays unassigned until this write [R5]
			if (i_cfg_write) begin
				phase_fn_q <= pick_fn(i_phase_b_spi_select, i_phase_b_timer_select,
					i_phase_b_gpio_select); // [R1]
				index_fn_q <= pick_fn(i_index_pin_spi_select, i_index_timer_select,
					i_index_gpio_select); // [R2]
			end
			// only bits 1 and 2 belong to these pins; the rest of the word is ignored
			if (i_pullup_write) begin
				pu_b_q <= i_port_c_pullup_enable[`PU_PHASE_B_BIT]; // [R6]
				pu_i_q <= i_port_c_pullup_enable[`PU_INDEX_BIT]; // [R7]
			end
		end
	end

	// marks the first edge after reset, when the variant's default is applied
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			full_q <= 1'b0;
		else
			full_q <= 1'b1;
	end

	// pull-ups are left on even while driving; only the enable bit turns them off
	always @* begin
		o_phase_b_pullup = pu_b_q; // [R6]
		o_index_pullup   = pu_i_q; // [R7]
	end

	// pin drive is combinational so spi data keeps the core's half-clock timing [R11] [R12]
	always @* begin
		o_phase_b_pin         = 1'b0;
		o_phase_b_pin_oe      = 1'b0;
		o_spi_mosi_in         = 1'b0;
		o_timer_b_channel_one = 1'b0;
		o_port_c_line_one     = 1'b0;
		o_quad_phase_b_in     = 1'b0;
		case (phase_fn_q)
			`FN_QUAD: o_quad_phase_b_in = i_phase_b_pin;
			`FN_TIMER: begin
				o_timer_b_channel_one = i_phase_b_pin;
				o_phase_b_pin         = i_timer_b_channel_one_out;
				o_phase_b_pin_oe      = i_timer_b_channel_one_oe;
			end
			`FN_SPI: begin
				o_phase_b_pin_oe = mosi_drive; // [R9]
				if (mosi_drive)
					o_phase_b_pin = i_spi_mosi_out; // [R9]
				else
					o_spi_mosi_in = i_phase_b_pin; // [R9]
			end
			`FN_GPIO: begin
				o_port_c_line_one = i_phase_b_pin;
				o_phase_b_pin     = i_port_c_line_one_out;
				o_phase_b_pin_oe  = i_port_c_line_one_dir; // [R8]
			end
			default: o_phase_b_pin_oe = 1'b0;
		endcase
	end

	// index pin routing; kept apart from phase b so each pin's defaults sit with its case
	always @* begin
		o_index_pin           = 1'b0;
		o_index_pin_oe        = 1'b0;
		o_spi_miso_in         = 1'b0;
		o_timer_b_channel_two = 1'b0;
		o_port_c_line_two     = 1'b0;
		o_quad_index_in       = 1'b0;
		case (index_fn_q)
			`FN_QUAD: o_quad_index_in = i_index_pin;
			`FN_TIMER: begin
				o_timer_b_channel_two = i_index_pin;
				o_index_pin           = i_timer_b_channel_two_out;
				o_index_pin_oe        = i_timer_b_channel_two_oe;
			end
			`FN_SPI: begin
				// unselected slave leaves the line floating [R13]
				o_index_pin_oe = miso_drive; // [R10]
				if (miso_drive)
					o_index_pin = i_spi_miso_out; // [R10] [R14]
				else if (i_spi_master_mode)
					o_spi_miso_in = i_index_pin; // [R10]
			end
			`FN_GPIO: begin
				o_port_c_line_two = i_index_pin;
				o_index_pin       = i_port_c_line_two_out;
				o_index_pin_oe    = i_port_c_line_two_dir; // [R8]
			end
			default: o_index_pin_oe = 1'b0;
		endcase
	end

endmodule // encoder_pin_function_mux

// [pin_mux_properties.sv]
`timescale 1ns/1ps
`include "pin_mux_map.vh"
module pin_mux_properties (
	input wire        i_clk, i_rst_b, i_cfg_write, i_phase_b_spi_select, i_pullup_write,
	input wire        i_spi_master_mode, i_spi1_slave_select_in_b, i_spi_mosi_out,
	input wire        i_spi_miso_out, i_phase_b_pin, i_index_pin,
	input wire [15:0] i_port_c_pullup_enable,
	input wire        o_phase_b_pin, o_phase_b_pin_oe, o_index_pin, o_index_pin_oe,
	input wire        o_spi_mosi_in, o_spi_miso_in, o_phase_b_pullup, o_index_pullup,
	input wire [2:0]  o_phase_b_function, o_index_function
);
	wire pb = o_phase_b_function == `FN_SPI;
	wire ix = o_index_function == `FN_SPI;
	wire ms = i_spi_master_mode;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	a_mosi_master_drive: assert property (pb && ms |-> o_phase_b_pin_oe &&
		o_phase_b_pin == i_spi_mosi_out) else $error("mosi not driven");
	a_mosi_slave_in: assert property (pb && !ms |-> !o_phase_b_pin_oe &&
		o_spi_mosi_in == i_phase_b_pin) else $error("mosi not input");
	a_miso_master_in: assert property (ix && ms |-> !o_index_pin_oe &&
		o_spi_miso_in == i_index_pin) else $error("miso not input");
	a_miso_slave_drive: assert property (ix && !ms && !i_spi1_slave_select_in_b |->
		o_index_pin_oe && o_index_pin == i_spi_miso_out) else $error("miso not driven");
	a_miso_unselected: assert property (ix && !ms && i_spi1_slave_select_in_b
		|-> !o_index_pin_oe) else $error("miso driven unselected");
	a_cfg_spi_route: assert property (i_cfg_write && i_phase_b_spi_select
		|=> pb) else $error("spi select lost");
	a_pullup_phase_off: assert property (i_pullup_write && !i_port_c_pullup_enable[1]
		|=> !o_phase_b_pullup) else $error("phase pull-up on");
	a_pullup_index_off: assert property (i_pullup_write && !i_port_c_pullup_enable[2]
		|=> !o_index_pullup) else $error("index pull-up on");
	a_unassigned_quiet: assert property (o_phase_b_function == `FN_NONE |->
		!o_phase_b_pin_oe && !o_spi_mosi_in) else $error("unassigned phase pin active");
	a_unassigned_index: assert property (o_index_function == `FN_NONE |->
		!o_index_pin_oe && !o_spi_miso_in) else $error("unassigned index pin active");
	c_master: cover property (pb && ms);
	c_unassigned: cover property (o_phase_b_function == `FN_NONE);
	c_slave: cover property (ix && !ms && !i_spi1_slave_select_in_b);
	c_pull: cover property (i_pullup_write);
endmodule // pin_mux_properties
bind encoder_pin_function_mux pin_mux_properties pin_mux_properties_i (.*);

// [spi_peer.sv]
`timescale 1ns/1ps
module spi_peer (
	input wire  i_clk, i_drive, i_val, i_pb_oe, i_pb_out, i_pb_pu, i_ix_oe, i_ix_out, i_ix_pu,
	output wire o_pb, o_ix
);
	reg pb_q, ix_q;
	// released lines take the peer's value while it drives, else the pull-up, else wander so stale data never looks valid
	assign o_pb = i_pb_oe ? i_pb_out : i_drive ? i_val : i_pb_pu ? 1'b1 : ~pb_q;
	assign o_ix = i_ix_oe ? i_ix_out : i_drive ? i_val : i_ix_pu ? 1'b1 : ~ix_q;
	always @(posedge i_clk) begin
		pb_q <= o_pb;
		ix_q <= o_ix;
	end
endmodule // spi_peer

// [encoder_pin_function_mux_tb.sv]
`timescale 1ns/1ps
`include "pin_mux_map.vh"
module encoder_pin_function_mux_tb;
	reg        clk = 0, rst_b = 0, sp = 0, tm = 0, gp = 0, wr = 0, puw = 0, ms = 0, ss_b = 1;
	reg        mo = 0, mi = 0, d1 = 0, drv = 0, val = 0;
	reg [15:0] pu = 16'hffff;
	wire       pb, ix, pbo, pboe, pbpu, ixo, ixoe, ixpu, mosi_in, miso_in, qb, qi;
	wire [2:0] pbf, ixf, rpbf, rixf;
	wire       t1, t2, l1, l2, rpboe, rixoe, rqb, rqi;
	integer    miscompares = 0, n_compared = 0;
	always #5 clk = ~clk;
	encoder_pin_function_mux encoder_pin_function_mux_i (.i_clk(clk), .i_rst_b(rst_b),
		.i_phase_b_spi_select(sp), .i_index_pin_spi_select(sp), .i_phase_b_timer_select(tm),
		.i_index_timer_select(tm), .i_phase_b_gpio_select(gp), .i_index_gpio_select(gp),
		.i_cfg_write(wr), .i_port_c_pullup_enable(pu), .i_pullup_write(puw),
		.i_spi_master_mode(ms), .i_spi1_slave_select_in_b(ss_b), .i_spi_mosi_out(mo),
		.i_spi_miso_out(mi), .o_spi_mosi_in(mosi_in), .o_spi_miso_in(miso_in),
		.i_timer_b_channel_one_out(mo), .i_timer_b_channel_one_oe(d1),
		.i_timer_b_channel_two_out(mi), .i_timer_b_channel_two_oe(d1),
		.o_timer_b_channel_one(t1), .o_timer_b_channel_two(t2),
		.i_port_c_line_one_out(mo), .i_port_c_line_one_dir(d1), .i_port_c_line_two_out(mi),
		.i_port_c_line_two_dir(~d1), .o_port_c_line_one(l1), .o_port_c_line_two(l2),
		.o_quad_phase_b_in(qb), .o_quad_index_in(qi), .i_phase_b_pin(pb), .o_phase_b_pin(pbo),
		.o_phase_b_pin_oe(pboe), .o_phase_b_pullup(pbpu), .i_index_pin(ix), .o_index_pin(ixo),
		.o_index_pin_oe(ixoe), .o_index_pullup(ixpu), .o_phase_b_function(pbf),
		.o_index_function(ixf));
	// reduced variant shares every input and is watched for its unassigned default
	encoder_pin_function_mux #(.FULL_VARIANT(0)) reduced_encoder_pin_function_mux_i (
		.i_clk(clk), .i_rst_b(rst_b),
		.i_phase_b_spi_select(sp), .i_index_pin_spi_select(sp), .i_phase_b_timer_select(tm),
		.i_index_timer_select(tm), .i_phase_b_gpio_select(gp), .i_index_gpio_select(gp),
		.i_cfg_write(wr), .i_port_c_pullup_enable(pu), .i_pullup_write(puw),
		.i_spi_master_mode(ms), .i_spi1_slave_select_in_b(ss_b), .i_spi_mosi_out(mo),
		.i_spi_miso_out(mi), .o_spi_mosi_in(), .o_spi_miso_in(),
		.i_timer_b_channel_one_out(mo), .i_timer_b_channel_one_oe(d1),
		.i_timer_b_channel_two_out(mi), .i_timer_b_channel_two_oe(d1),
		.o_timer_b_channel_one(), .o_timer_b_channel_two(),
		.i_port_c_line_one_out(mo), .i_port_c_line_one_dir(d1), .i_port_c_line_two_out(mi),
		.i_port_c_line_two_dir(~d1), .o_port_c_line_one(), .o_port_c_line_two(),
		.o_quad_phase_b_in(rqb), .o_quad_index_in(rqi), .i_phase_b_pin(pb), .o_phase_b_pin(),
		.o_phase_b_pin_oe(rpboe), .o_phase_b_pullup(), .i_index_pin(ix), .o_index_pin(),
		.o_index_pin_oe(rixoe), .o_index_pullup(), .o_phase_b_function(rpbf),
		.o_index_function(rixf));
	spi_peer spi_peer_i (.i_clk(clk), .i_drive(drv), .i_val(val), .i_pb_oe(pboe),
		.i_pb_out(pbo), .i_pb_pu(pbpu), .i_ix_oe(ixoe), .i_ix_out(ixo), .i_ix_pu(ixpu),
		.o_pb(pb), .o_ix(ix));
	task chk(input [7:0] got, input [7:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	task cfg(input s, input t, input g);
		{sp, tm, gp, wr} = {s, t, g, 1'b1};
		step;
		wr = 0;
		#1;
	endtask
	task conclude;
		$display("%0d compared, %0d wrong", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#5000;
		miscompares = miscompares + 1;
		conclude;
	end
	initial begin
		repeat (5) step;
		rst_b = 1;
		step;
		{drv, val} = 2'b11;
		#1;
		chk({pbf, qb}, {`FN_QUAD, 1'b1});
		chk({ixf, qi}, {`FN_QUAD, 1'b1});
		chk({rpbf, rixf}, {`FN_NONE, `FN_NONE});
		chk({rpboe, rixoe, rqb, rqi}, 4'h0);
		cfg(1, 0, 0);
		{ms, mo, val} = 3'b101;
		#1;
		chk(pbf, `FN_SPI);
		chk(ixf, `FN_SPI);
		chk({rpbf, rixf}, {`FN_SPI, `FN_SPI});
		chk({pboe, pb, ixoe, miso_in}, 4'h9);
		{ms, ss_b, mi, val} = 4'b0001;
		#1;
		chk({pboe, mosi_in, ixoe, ix}, 4'h6);
		ss_b = 1;
		#1;
		chk({ixoe, miso_in}, 2'b00);
		cfg(0, 1, 0);
		{d1, mo, mi} = 3'b101;
		#1;
		chk({pbf, ixf}, {`FN_TIMER, `FN_TIMER});
		chk({pboe, ixoe, t1, t2, qb, qi}, 6'h34);
		cfg(1, 1, 1);
		chk({pbf, ixf}, {`FN_SPI, `FN_SPI});
		cfg(0, 0, 1);
		{d1, mo, val} = 3'b110;
		#1;
		chk({pboe, ixoe, l1, l2}, 4'ha);
		d1 = 0;
		#1;
		chk({pboe, ixoe, l1, l2}, 4'h5);
		{pu, puw} = {16'hfff9, 1'b1};
		step;
		puw = 0;
		chk({pbpu, ixpu}, 2'b00);
		#1;
		{pu, puw} = {16'h0002, 1'b1};
		step;
		puw = 0;
		chk({pbpu, ixpu}, 2'b10);
		rst_b = 0;
		step;
		rst_b = 1;
		step;
		chk({pbf, ixf}, {`FN_QUAD, `FN_QUAD});
		chk({rpbf, rixf}, {`FN_NONE, `FN_NONE});
		chk({pbpu, ixpu}, 2'b11);
		conclude;
	end
endmodule // encoder_pin_function_mux_tb
